// [src/lutcs_defs.vh]
// register map, field layout, reset values and timing constants of the lookup control block
`ifndef LUTCS_DEFS_VH
`define LUTCS_DEFS_VH

// printed offsets are not all multiples of four: these are indices, byte address = 4 * index
`define LUTCS_IDX_AGE_PERIOD 12'h313
`define LUTCS_IDX_EVENT_STATUS 12'h314
`define LUTCS_IDX_EVENT_MASK 12'h315
`define LUTCS_IDX_FULL_FAIL_INDEX 12'h316
`define LUTCS_IDX_FAIL_LEARN_INDEX 12'h318
`define LUTCS_IDX_HOST_ACCESS_INDEX 12'h31A
`define LUTCS_IDX_UNICAST_FWD 12'h320
`define LUTCS_IDX_MULTICAST_FWD 12'h324
`define LUTCS_IDX_VLAN_FWD 12'h328

`define LUTCS_AGE_PERIOD_RESET 8'h4B
`define LUTCS_MASK_RESET 3'h7
`define LUTCS_FWD_ENABLE_BIT 31
`define LUTCS_EVT_LEARN_FAIL 2
`define LUTCS_EVT_ALMOST_FULL 1
`define LUTCS_EVT_WRITE_FAIL 0

`define LUTCS_CLK_HZ 25000000
`define LUTCS_TICK_S 1

`endif

// [src/lutcs_top.v]
// lookup table control and status registers with AHB-Lite slave, aging tick and unknown forwarding
`timescale 1ns/10ps
`default_nettype none
`include "lutcs_defs.vh"

module lutcs_top #(
    parameter TICK_CYCLES = `LUTCS_CLK_HZ * `LUTCS_TICK_S,
    parameter AGE_CNT_W = 8
) (
    input wire clk,
    input wire reset,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // table engine events
    input wire learn_fail_evt,
    input wire [9:0] learn_fail_bucket,
    input wire static_write_evt,
    input wire static_write_ok,
    input wire [2:0] bucket_valid_count,
    input wire [11:0] static_write_entry,
    input wire [9:0] static_write_bucket,
    input wire host_access_evt,
    input wire [9:0] host_access_bucket,
    // aging check for one dynamic entry
    input wire [AGE_CNT_W-1:0] entry_age_count,
    input wire [31:0] entry_age_seconds,
    output reg entry_expired,
    output reg age_tick,
    // unknown packet classification
    input wire pkt_valid,
    input wire pkt_unknown_vlan,
    input wire pkt_unknown_unicast,
    input wire pkt_unknown_multicast,
    output reg fwd_valid,
    output reg fwd_enable,
    output reg [2:0] fwd_ports,
    output wire [7:0] age_period_out,
    output wire lookup_engine_irq_bit,
    output wire irq
);

    reg [7:0] age_period;
    reg [2:0] event_status;
    reg [2:0] event_mask;
    reg [11:0] full_fail_index;
    reg [9:0] fail_learn_index;
    reg [9:0] host_access_index;
    reg uc_enable;
    reg [2:0] uc_ports;
    reg mc_enable;
    reg [2:0] mc_ports;
    reg vlan_enable;
    reg [2:0] vlan_ports;

    // data phase capture
    reg dp_write;
    reg dp_read;
    reg [11:0] dp_index;

    wire addr_phase = hsel && hready && htrans[1];
    wire [11:0] next_index = haddr[13:2];
    wire wr_go = dp_write;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign age_period_out = age_period;

    always @(posedge clk) begin
        if (reset) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_index <= 12'h000;
        end else begin
            dp_write <= addr_phase && hwrite;
            dp_read <= addr_phase && !hwrite;
            dp_index <= next_index;
        end
    end

    // read data prepared at address phase so it stands in the zero-wait data phase
    // reserved bits of every register read back as zero
    reg [31:0] next_hrdata;
    always @* begin
        next_hrdata = 32'h00000000;
        case (next_index)
            `LUTCS_IDX_AGE_PERIOD: begin
                next_hrdata[7:0] = age_period;
            end
            `LUTCS_IDX_EVENT_STATUS: begin
                next_hrdata[2:0] = event_status;
            end
            `LUTCS_IDX_EVENT_MASK: begin
                next_hrdata[2:0] = event_mask;
            end
            `LUTCS_IDX_FULL_FAIL_INDEX: begin
                next_hrdata[11:0] = full_fail_index;
            end
            `LUTCS_IDX_FAIL_LEARN_INDEX: begin
                next_hrdata[9:0] = fail_learn_index;
            end
            `LUTCS_IDX_HOST_ACCESS_INDEX: begin
                next_hrdata[9:0] = host_access_index;
            end
            `LUTCS_IDX_UNICAST_FWD: begin
                next_hrdata[`LUTCS_FWD_ENABLE_BIT] = uc_enable;
                next_hrdata[2:0] = uc_ports;
            end
            `LUTCS_IDX_MULTICAST_FWD: begin
                next_hrdata[`LUTCS_FWD_ENABLE_BIT] = mc_enable;
                next_hrdata[2:0] = mc_ports;
            end
            `LUTCS_IDX_VLAN_FWD: begin
                next_hrdata[`LUTCS_FWD_ENABLE_BIT] = vlan_enable;
                next_hrdata[2:0] = vlan_ports;
            end
            default: begin
                next_hrdata = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= next_hrdata;
        end
    end

    // control registers; one write strobe each, so a stray index cannot touch two of them
    wire we_age = wr_go && (dp_index == `LUTCS_IDX_AGE_PERIOD);
    wire we_mask = wr_go && (dp_index == `LUTCS_IDX_EVENT_MASK);
    wire we_uc = wr_go && (dp_index == `LUTCS_IDX_UNICAST_FWD);
    wire we_mc = wr_go && (dp_index == `LUTCS_IDX_MULTICAST_FWD);
    wire we_vlan = wr_go && (dp_index == `LUTCS_IDX_VLAN_FWD);

    always @(posedge clk) begin
        if (reset) begin
            age_period <= `LUTCS_AGE_PERIOD_RESET;
        end else if (we_age) begin
            age_period <= hwdata[7:0];
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            event_mask <= `LUTCS_MASK_RESET;
        end else if (we_mask) begin
            event_mask <= hwdata[2:0];
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            uc_enable <= 1'b0;
            uc_ports <= 3'h0;
        end else if (we_uc) begin
            uc_enable <= hwdata[`LUTCS_FWD_ENABLE_BIT];
            uc_ports <= hwdata[2:0];
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            mc_enable <= 1'b0;
            mc_ports <= 3'h0;
        end else if (we_mc) begin
            mc_enable <= hwdata[`LUTCS_FWD_ENABLE_BIT];
            mc_ports <= hwdata[2:0];
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            vlan_enable <= 1'b0;
            vlan_ports <= 3'h0;
        end else if (we_vlan) begin
            vlan_enable <= hwdata[`LUTCS_FWD_ENABLE_BIT];
            vlan_ports <= hwdata[2:0];
        end
    end

    // event decode from the table engine
    wire ev_learn = learn_fail_evt;
    wire ev_almost = static_write_evt && static_write_ok &&
        (bucket_valid_count == 3'd2 || bucket_valid_count == 3'd3);
    wire ev_wfail = static_write_evt && !static_write_ok;
    wire [2:0] ev_vec = {ev_learn, ev_almost, ev_wfail};
    wire clr_hit = wr_go && (dp_index == `LUTCS_IDX_EVENT_STATUS);
    wire [2:0] clr_vec = clr_hit ? hwdata[2:0] : 3'h0;

    // set wins over a write-one-clear in the same cycle; mask does not gate recording
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_evt
            always @(posedge clk) begin
                if (reset) begin
                    event_status[g] <= 1'b0;
                end else if (ev_vec[g]) begin
                    event_status[g] <= 1'b1;
                end else if (clr_vec[g]) begin
                    event_status[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign lookup_engine_irq_bit = |event_status;
    assign irq = |(event_status & ~event_mask);

    // index capture; failed write uses only the low ten bits of the shared field
    always @(posedge clk) begin
        if (reset) begin
            full_fail_index <= 12'h000;
        end else if (ev_almost) begin
            full_fail_index <= static_write_entry;
        end else if (ev_wfail) begin
            full_fail_index <= {2'h0, static_write_bucket};
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            fail_learn_index <= 10'h000;
        end else if (ev_learn) begin
            fail_learn_index <= learn_fail_bucket;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            host_access_index <= 10'h000;
        end else if (host_access_evt) begin
            host_access_index <= host_access_bucket;
        end
    end

    // one-second tick divider; long count is a parameter so simulation can shorten it
    reg [31:0] tick_div;
    reg [31:0] next_tick_div;
    always @* begin
        if (tick_div >= TICK_CYCLES - 1) begin
            next_tick_div = 32'h00000000;
        end else begin
            next_tick_div = tick_div + 32'h00000001;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            tick_div <= 32'h00000000;
            age_tick <= 1'b0;
        end else begin
            tick_div <= next_tick_div;
            age_tick <= (tick_div >= TICK_CYCLES - 1);
        end
    end

    // product fits 16 bits for an 8-bit age count; zero count never expires
    wire [15:0] age_limit = age_period * {{(16-AGE_CNT_W){1'b0}}, entry_age_count};
    reg next_entry_expired;
    always @* begin
        next_entry_expired = 1'b0;
        if (age_limit != 16'h0000) begin
            next_entry_expired = (entry_age_seconds >= {16'h0000, age_limit});
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            entry_expired <= 1'b0;
        end else begin
            entry_expired <= next_entry_expired;
        end
    end

    // unknown forwarding decision, vlan id checked before unicast before multicast
    reg next_fwd_enable;
    reg [2:0] next_fwd_ports;
    wire pkt_unknown_any = pkt_unknown_vlan || pkt_unknown_unicast || pkt_unknown_multicast;
    always @* begin
        next_fwd_enable = 1'b0;
        next_fwd_ports = 3'h0;
        if (pkt_unknown_vlan) begin
            next_fwd_enable = vlan_enable;
            next_fwd_ports = vlan_ports;
        end else if (pkt_unknown_unicast) begin
            next_fwd_enable = uc_enable;
            next_fwd_ports = uc_ports;
        end else if (pkt_unknown_multicast) begin
            next_fwd_enable = mc_enable;
            next_fwd_ports = mc_ports;
        end
        // a disabled category forwards to no port at all, whatever its port bits say
        if (!next_fwd_enable) begin
            next_fwd_ports = 3'h0;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            fwd_valid <= 1'b0;
            fwd_enable <= 1'b0;
            fwd_ports <= 3'h0;
        end else begin
            fwd_valid <= pkt_valid && pkt_unknown_any;
            fwd_enable <= next_fwd_enable;
            fwd_ports <= next_fwd_ports;
        end
    end

endmodule
`default_nettype wire

// [tb/lutcs_chk.sv]
// port assertions for the lookup control block
`timescale 1ns/10ps
`default_nettype none
module lutcs_chk #(parameter AGE_CNT_W = 8, parameter TICK_CYCLES = 10) (
    input wire logic clk,
    input wire logic reset,
    input wire logic learn_fail_evt,
    input wire logic static_write_evt,
    input wire logic static_write_ok,
    input wire logic [2:0] bucket_valid_count,
    input wire logic [AGE_CNT_W-1:0] entry_age_count,
    input wire logic [31:0] entry_age_seconds,
    input wire logic entry_expired,
    input wire logic age_tick,
    input wire logic fwd_enable,
    input wire logic [2:0] fwd_ports,
    input wire logic [7:0] age_period_out,
    input wire logic lookup_engine_irq_bit,
    input wire logic irq
);
    wire [AGE_CNT_W+7:0] prod = age_period_out * entry_age_count;
    int gap;
    logic seen;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // gap counts cycles since the last tick, so a stuck or early tick both show
    always @(posedge clk) begin
        if (reset || age_tick) gap <= 0; else gap <= gap + 1;
        seen <= !reset && (seen || age_tick);
    end
    sequence s_flag; ##1 lookup_engine_irq_bit; endsequence
    property p_rst; $fell(reset) |-> age_period_out == 8'h4B && !irq && !lookup_engine_irq_bit;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_expire; 1'b1 |=> entry_expired == $past(prod != 0 && 32'(prod) <= entry_age_seconds);
    endproperty
    a_expire: assert property (p_expire) else $error("expiry wrong");
    property p_learn; learn_fail_evt |-> s_flag; endproperty
    a_learn: assert property (p_learn) else $error("learn fail not flagged");
    property p_almost; static_write_evt && static_write_ok && bucket_valid_count[2:1] == 2'h1
        |-> s_flag; endproperty
    a_almost: assert property (p_almost) else $error("almost full not flagged");
    property p_fail; static_write_evt && !static_write_ok |-> s_flag; endproperty
    a_fail: assert property (p_fail) else $error("write fail not flagged");
    property p_irq; irq |-> lookup_engine_irq_bit; endproperty
    a_irq: assert property (p_irq) else $error("irq without status");
    property p_fwd; !fwd_enable |-> fwd_ports == 3'h0; endproperty
    a_fwd: assert property (p_fwd) else $error("ports while disabled");
    property p_tick; seen |-> gap < TICK_CYCLES && age_tick == (gap == TICK_CYCLES - 1);
    endproperty
    a_tick: assert property (p_tick) else $error("tick spacing wrong");
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the lookup control block
`timescale 1ns/10ps
`default_nettype none
`include "lutcs_defs.vh"
module testbench;
    logic clk = 0, reset = 1, hwrite = 0, learn_fail_evt = 0, static_write_evt = 0;
    logic static_write_ok = 0, host_access_evt = 0, pkt_valid = 0;
    logic pkt_unknown_vlan = 0, pkt_unknown_unicast = 0, pkt_unknown_multicast = 0;
    logic [1:0] htrans = 0;
    logic [2:0] bucket_valid_count = 0;
    logic [9:0] learn_fail_bucket = 0, static_write_bucket = 0, host_access_bucket = 0;
    logic [11:0] static_write_entry = 0;
    logic [7:0] entry_age_count = 0;
    logic [31:0] haddr = 0, hwdata = 0, entry_age_seconds = 0, rv;
    wire hreadyout, hresp, entry_expired, age_tick, fwd_valid, fwd_enable, eng_irq, irq;
    wire [2:0] fwd_ports;
    wire [7:0] age_period_out;
    wire [31:0] hrdata;
    int num_errors = 0, n_compared = 0, seed = 94052;
    lutcs_top #(.TICK_CYCLES(10), .AGE_CNT_W(8)) u_dut (.clk, .reset, .hsel(1'b1), .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .learn_fail_evt, .learn_fail_bucket, .static_write_evt, .static_write_ok,
        .bucket_valid_count, .static_write_entry, .static_write_bucket, .host_access_evt,
        .host_access_bucket, .entry_age_count, .entry_age_seconds, .entry_expired, .age_tick,
        .pkt_valid, .pkt_unknown_vlan, .pkt_unknown_unicast, .pkt_unknown_multicast, .fwd_valid,
        .fwd_enable, .fwd_ports, .age_period_out, .lookup_engine_irq_bit(eng_irq), .irq);
    initial forever #20 clk = ~clk;
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdy;
        int i;
        @(posedge clk);
        for (i = 0; i < 20 && hreadyout !== 1'b1; i++) @(posedge clk);
        if (i == 20) begin
            num_errors++;
            give_verdict();
        end
    endtask
    task automatic xfer(logic w, logic [11:0] idx, logic [31:0] d);
        haddr <= {18'h0, idx, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rv = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic rd(string nm, logic [11:0] idx, logic [31:0] e);
        xfer(0, idx, 32'h0);
        chk(nm, e, rv);
    endtask
    task automatic pulse(logic [2:0] k);
        {learn_fail_evt, static_write_evt, host_access_evt} <= k;
        @(posedge clk);
        {learn_fail_evt, static_write_evt, host_access_evt} <= 3'h0;
    endtask
    // outputs are read mid-cycle, away from the edge that moves them
    // sel: 0 engine irq, 1 irq, 2 {fwd_valid, fwd_enable, fwd_ports}, else entry_expired
    task automatic port_chk(string nm, logic [31:0] e, int sel);
        @(negedge clk);
        case (sel)
            0: chk(nm, e, {31'h0, eng_irq});
            1: chk(nm, e, {31'h0, irq});
            2: chk(nm, e, {27'h0, fwd_valid, fwd_enable, fwd_ports});
            default: chk(nm, e, {31'h0, entry_expired});
        endcase
        @(posedge clk);
    endtask
    function automatic logic aexp(logic [7:0] p, logic [1:0] n, logic [9:0] s);
        int t;
        t = p * n;
        return t != 0 && s >= t;
    endfunction
    function automatic logic [3:0] fexp(logic [2:0] f, logic [31:0] v, u, m);
        logic [31:0] r;
        r = f[2] ? v : (f[1] ? u : m);
        return {r[31], r[31] ? r[2:0] : 3'h0};
    endfunction
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
    initial begin
        int c, k;
        logic [31:0] v, u, m;
        logic [9:0] b;
        logic [11:0] e;
        logic [7:0] p;
        repeat (6) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        rd("period", `LUTCS_IDX_AGE_PERIOD, 32'h4B);
        rd("mask", `LUTCS_IDX_EVENT_MASK, 32'h7);
        rd("status", `LUTCS_IDX_EVENT_STATUS, 32'h0);
        rd("unicast", `LUTCS_IDX_UNICAST_FWD, 32'h0);
        rd("multicast", `LUTCS_IDX_MULTICAST_FWD, 32'h0);
        rd("unmapped", 12'h300, 32'h0);
        v = $random(seed);
        xfer(1, `LUTCS_IDX_AGE_PERIOD, v);
        rd("period", `LUTCS_IDX_AGE_PERIOD, {24'h0, v[7:0]});
        p = v[7:0];
        chk("period out", {24'h0, p}, {24'h0, age_period_out});
        repeat (60) begin
            v = $random(seed);
            entry_age_count <= {6'h0, v[1:0]};
            entry_age_seconds <= {22'h0, v[11:2]};
            @(posedge clk);
            port_chk("expired", aexp(p, v[1:0], v[11:2]), 3);
        end
        // the exact limit is the first second that expires
        entry_age_count <= 8'h02;
        entry_age_seconds <= {23'h0, p, 1'b0};
        @(posedge clk);
        port_chk("expired limit", aexp(p, 2'h2, {1'b0, p, 1'b0}), 3);
        entry_age_seconds <= {23'h0, p, 1'b0} - 32'h1;
        @(posedge clk);
        port_chk("expired below", 32'h0, 3);
        $display("test registers and aging done");
        b = 10'($random(seed));
        learn_fail_bucket <= b;
        pulse(3'h4);
        rd("status", `LUTCS_IDX_EVENT_STATUS, 32'h4);
        rd("learn index", `LUTCS_IDX_FAIL_LEARN_INDEX, {22'h0, b});
        port_chk("engine irq", 32'h1, 0);
        port_chk("irq masked", 32'h0, 1);
        xfer(1, `LUTCS_IDX_EVENT_MASK, 32'h3);
        port_chk("irq", 32'h1, 1);
        xfer(1, `LUTCS_IDX_EVENT_STATUS, 32'h4);
        port_chk("engine irq", 32'h0, 0);
        xfer(1, `LUTCS_IDX_EVENT_MASK, 32'h0);
        for (c = 0; c < 5; c++) begin
            e = 12'($random(seed));
            b = 10'($random(seed));
            static_write_ok <= (c < 4);
            bucket_valid_count <= c[2:0];
            static_write_entry <= e;
            static_write_bucket <= b;
            pulse(3'h2);
            rd("status", `LUTCS_IDX_EVENT_STATUS, c == 4 ? 32'h1 : {30'h0, c >= 2, 1'b0});
            if (c >= 2)
                rd("index0", `LUTCS_IDX_FULL_FAIL_INDEX, c == 4 ? {22'h0, b} : {20'h0, e});
            port_chk("irq", {31'h0, c >= 2}, 1);
            xfer(1, `LUTCS_IDX_EVENT_STATUS, 32'h7);
        end
        b = 10'($random(seed));
        host_access_bucket <= b;
        pulse(3'h1);
        xfer(1, `LUTCS_IDX_HOST_ACCESS_INDEX, 32'hFFFF);
        rd("host index", `LUTCS_IDX_HOST_ACCESS_INDEX, {22'h0, b});
        $display("test events done");
        for (k = 0; k < 4; k++) begin
            v = k == 0 ? 32'h80000001 : $random(seed);
            u = k == 0 ? 32'h80000002 : $random(seed);
            m = k == 0 ? 32'h80000004 : $random(seed);
            xfer(1, `LUTCS_IDX_VLAN_FWD, v);
            xfer(1, `LUTCS_IDX_UNICAST_FWD, u);
            xfer(1, `LUTCS_IDX_MULTICAST_FWD, m);
            {v, u, m} = {v, u, m} & {3{32'h80000007}};
            rd("unicast", `LUTCS_IDX_UNICAST_FWD, u);
            rd("multicast", `LUTCS_IDX_MULTICAST_FWD, m);
            rd("vlan", `LUTCS_IDX_VLAN_FWD, v);
            for (c = 1; c < 8; c++) begin
                pkt_valid <= 1;
                {pkt_unknown_vlan, pkt_unknown_unicast, pkt_unknown_multicast} <= c[2:0];
                @(posedge clk);
                port_chk("forward", {1'b1, fexp(c[2:0], v, u, m)}, 2);
            end
        end
        {pkt_valid, pkt_unknown_vlan, pkt_unknown_unicast, pkt_unknown_multicast} <= 4'h0;
        @(posedge clk);
        port_chk("forward idle", 32'h0, 2);
        $display("test forwarding done");
        give_verdict();
    end
endmodule
bind lutcs_top lutcs_chk #(.AGE_CNT_W(AGE_CNT_W), .TICK_CYCLES(TICK_CYCLES)) u_chk (.clk,
    .reset, .learn_fail_evt, .static_write_evt, .static_write_ok, .bucket_valid_count,
    .entry_age_count, .entry_age_seconds, .entry_expired, .age_tick, .fwd_enable, .fwd_ports,
    .age_period_out, .lookup_engine_irq_bit, .irq);
`default_nettype wire
